// *** logic/status_router_pkg.sv ***
// status router package: selection codes, reset defaults, flag and register layouts
// assumes a 32-bit Avalon-MM register port and a 50 MHz control clock
package status_router_pkg;

    // selection code width (codes up to 9999)
    localparam int SEL_W = 14;

    // polarity bands
    localparam logic [13:0] SEL_NEG_BASE = 14'h0064;  // 100
    localparam logic [13:0] SEL_NEG_TOP  = 14'h00c7;  // 199
    localparam logic [13:0] SEL_NONE     = 14'h270f;  // 9999, no function

    // function codes (positive band)
    localparam logic [6:0] FN_RUN     = 7'h00;  // 0
    localparam logic [6:0] FN_UPFREQ  = 7'h01;  // 1
    localparam logic [6:0] FN_READY   = 7'h0b;  // 11
    localparam logic [6:0] FN_SLEEP   = 7'h46;  // 70
    localparam logic [6:0] FN_SAFE    = 7'h50;  // 80
    localparam logic [6:0] FN_SAFETY_CIRCUIT_HEALTHY   = 7'h51;  // 81
    localparam logic [6:0] FN_LIFE    = 7'h5a;  // 90
    localparam logic [6:0] FN_PWROFF  = 7'h5b;  // 91
    localparam logic [6:0] FN_CURAVG  = 7'h5d;  // 93
    localparam logic [6:0] FN_MAINT   = 7'h5f;  // 95
    localparam logic [6:0] FN_REMOTE  = 7'h60;  // 96
    localparam logic [6:0] FN_WARN    = 7'h62;  // 98
    localparam logic [6:0] FN_TRIP    = 7'h63;  // 99

    // reset values of the three selectors
    localparam logic [13:0] FIRST_SEL_RST  = 14'h0000;  // motion-active, positive
    localparam logic [13:0] SECOND_SEL_RST = 14'h0001;  // up to frequency, positive
    localparam logic [13:0] RELAY_SEL_RST  = 14'h0063;  // trip, positive

    // register byte offsets
    localparam logic [3:0] REG_FIRST_SEL  = 4'h0;
    localparam logic [3:0] REG_SECOND_SEL = 4'h4;
    localparam logic [3:0] REG_RELAY_SEL  = 4'h8;
    localparam logic [3:0] REG_REMOTE     = 4'hc;
    localparam logic [3:0] REG_STATUS     = 4'h0;  // at word index 4 (byte 0x10)
    localparam logic [4:0] REG_STATUS_ADDR = 5'h10;

    // status word bit positions
    localparam int ST_TERM_LSB  = 0;   // terminals at bits 2:0
    localparam int ST_READY     = 3;
    localparam int ST_RUN       = 4;
    localparam int ST_TRIP      = 5;
    localparam int ST_REJECT    = 6;   // sticky: a selector write was refused since last cleared

    // drive state from the control core
    typedef struct packed {
        logic main_power_ok;      // main circuit supply present
        logic undervoltage;       // power failure or undervoltage
        logic reset_done;         // start-up reset finished
        logic fault_active;       // drive fault condition
        logic output_stop_input;  // output stop input on
        logic safety_stop;        // safety stop function active
        logic dc_brake;           // dc injection braking
        logic restart_coasting;   // coasting during auto restart
        logic freq_at_start;      // output frequency >= starting frequency
        logic fault_reset;        // fault reset pulse
    } drive_state_s;

    // detector flags from the surrounding logic
    typedef struct packed {
        logic frequency_reached_flag;
        logic accel_time_zero;      // accel/decel time set to 0 s
        logic pid_sleep;
        logic safety_circuit_fault;
        logic cpu_fault;
        logic life_alarm_flag;
        logic power_off_fault_flag;
        logic current_average_pulses;
        logic maintenance_due_flag;
        logic warning_flag;
    } detector_s;

endpackage

// *** logic/status_output_router.sv ***
// status output router: three assignable output terminals with polarity select
// assumes synchronous drive-state inputs and a single Avalon-MM master
//
// How it works
// R1: codes 0-99 conduct when function true; codes 100-199 invert.
// R2: any function may be routed to several terminals, each with own polarity.
// R3: second open-collector selector refuses the no-function code 9999.
// R4: relay selector refuses the current-average pulse codes 93 and 193.
// R5: codes 70/170 follow the process-control sleep flag.
// R6: codes 80/180 follow the safety-stop active flag.
// R7: codes 81/181 stay on unless safety circuit or processor fault.
// R8: codes 90/190 follow the component life alarm.
// R9: codes 91/191 follow the power-off fault flag.
// R10: codes 93/193 pass the current-average pulse train.
// R11: codes 95/195 follow the maintenance due flag.
// R12: codes 96/196 follow a software-written remote output bit.
// R13: codes 98/198 follow the warning flag.
// R14: codes 99/199 trip flag sets on fault, clears only on fault reset.
// R15: up-to-frequency held steady when accel/decel time is zero; here zero time passes the flag direct, else one cycle late.
// R16: codes 11/111 ready flag, on when able to start or running.
// R17: codes 0/100 motion flag on at or above start frequency, off stopped/braking.
// R18: output shutoff by fault, stop input or safety stop clears ready and motion.
// R19: ready stays on under dc braking and restart, drops on undervoltage.
// R20: ready off while main circuit supply is absent.
// R21: first terminal resets to motion-active, positive polarity.
// R22: relay resets to trip flag; trip may be written to any terminal.
// R23: terminal outputs registered; selection change acts at next clock edge.
// R24: unknown selection code leaves terminal non-conducting.
//
// The Avalon-MM interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
module status_output_router
    import status_router_pkg::*;
(
    input  wire logic         core_clk,
    input  wire logic         srst,
    input  wire logic [4:0]   avs_address,
    input  wire logic         avs_read,
    input  wire logic         avs_write,
    input  wire logic [31:0]  avs_writedata,
    input  wire logic [3:0]   avs_byteenable,
    output logic [31:0]       avs_readdata,
    output logic              avs_waitrequest,
    input  wire drive_state_s drive_state,
    input  wire detector_s    detectors,
    output logic              first_terminal_on,
    output logic              second_terminal_on,
    output logic              relay_terminal_on
);

    // selectors and flags
    logic [13:0] first_terminal_select_reg;
    logic [13:0] second_terminal_select_reg;
    logic [13:0] relay_terminal_select_reg;
    logic        remote_output_bit_reg;
    logic        reject_reg;
    logic        trip_flag_reg;
    logic        drive_ready_flag;
    logic        motion_flag;
    logic        su_hold_reg;
    logic        su_flag;
    logic        ack_reg;
    logic [2:0]  term_next;

    // every property below runs on the control clock and sleeps through reset
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (srst);

    // codes with a function behind them; anything else leaves the terminal off
    function automatic logic fn_defined(input logic [6:0] c);
        case (c)
            FN_RUN, FN_UPFREQ, FN_READY, FN_SLEEP, FN_SAFE, FN_SAFETY_CIRCUIT_HEALTHY, FN_LIFE,
            FN_PWROFF, FN_CURAVG, FN_MAINT, FN_REMOTE, FN_WARN, FN_TRIP:
                return 1'b1;
            default:
                return 1'b0;
        endcase
    endfunction

    // map a selection code to a terminal level, false for unmapped codes
    function automatic logic route(input logic [13:0] sel, input logic [127:0] fn);
        logic       neg;
        logic [6:0] code;
        neg  = (sel >= SEL_NEG_BASE) && (sel <= SEL_NEG_TOP);
        code = neg ? 7'(sel - SEL_NEG_BASE) : sel[6:0];
        if ((sel > SEL_NEG_TOP) || !fn_defined(code))
            return 1'b0;                      // R24
        return fn[code] ^ neg;                // R1
    endfunction

    // function vector; entries for undefined codes stay 0 and route never reads them
    logic [127:0] fn_vec;
    always_comb
    begin
        fn_vec            = '0;
        fn_vec[FN_RUN]    = motion_flag;                                // R17
        fn_vec[FN_UPFREQ] = su_flag;                                    // R15
        fn_vec[FN_READY]  = drive_ready_flag;                           // R16
        fn_vec[FN_SLEEP]  = detectors.pid_sleep;                        // R5
        fn_vec[FN_SAFE]   = drive_state.safety_stop;                    // R6
        fn_vec[FN_SAFETY_CIRCUIT_HEALTHY]  = !(detectors.safety_circuit_fault
                              || detectors.cpu_fault);                  // R7
        fn_vec[FN_LIFE]   = detectors.life_alarm_flag;                  // R8
        fn_vec[FN_PWROFF] = detectors.power_off_fault_flag;             // R9
        fn_vec[FN_CURAVG] = detectors.current_average_pulses;           // R10
        fn_vec[FN_MAINT]  = detectors.maintenance_due_flag;             // R11
        fn_vec[FN_REMOTE] = remote_output_bit_reg;                      // R12
        fn_vec[FN_WARN]   = detectors.warning_flag;                     // R13
        fn_vec[FN_TRIP]   = trip_flag_reg;                              // R14
    end

    // shutoff covers fault, stop input and safety stop
    logic shutoff;
    assign shutoff = drive_state.fault_active || drive_state.output_stop_input
                     || drive_state.safety_stop;

    // ready: dc braking and restart do not clear it
    assign drive_ready_flag = drive_state.reset_done && drive_state.main_power_ok // R20
                              && !drive_state.undervoltage                       // R19
                              && !shutoff;                                       // R18
    // motion: off when stopped, braking or shut off
    assign motion_flag = drive_state.freq_at_start && !drive_state.dc_brake      // R17
                         && !shutoff;                                            // R18

    // trip flag: fault sets, only fault reset clears; set wins
    always_ff @(posedge core_clk)
    begin
        if (srst)
            trip_flag_reg <= 1'b0;
        else if (drive_state.fault_active)
            trip_flag_reg <= 1'b1;                // R14
        else if (drive_state.fault_reset)
            trip_flag_reg <= 1'b0;                // R14
    end

    // up-to-frequency: with zero ramp time the flag is taken as it stands
    always_ff @(posedge core_clk)
    begin
        if (srst)
            su_hold_reg <= 1'b0;
        else
            su_hold_reg <= detectors.frequency_reached_flag;
    end
    assign su_flag = detectors.accel_time_zero ? detectors.frequency_reached_flag
                                               : su_hold_reg;  // R15

    // write qualification per selector
    logic        wr_ok;
    logic [13:0] wr_code;
    logic        refuse_second;
    logic        refuse_relay;
    assign wr_ok   = avs_write && ack_reg && (&avs_byteenable[1:0]);
    assign wr_code = avs_writedata[13:0];
    assign refuse_second = (wr_code == SEL_NONE);                              // R3
    assign refuse_relay  = (wr_code == 14'(FN_CURAVG))
                           || (wr_code == 14'(FN_CURAVG) + SEL_NEG_BASE);      // R4

    // code validity: bands or no-function value
    function automatic logic code_legal(input logic [13:0] c);
        return (c <= SEL_NEG_TOP) || (c == SEL_NONE);
    endfunction

    // selector registers; every terminal may carry any function except current average (93/193) on the relay
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            first_terminal_select_reg  <= FIRST_SEL_RST;   // R21
            second_terminal_select_reg <= SECOND_SEL_RST;
            relay_terminal_select_reg  <= RELAY_SEL_RST;   // R22
            remote_output_bit_reg      <= 1'b0;
            reject_reg                 <= 1'b0;
        end
        else if (wr_ok)
        begin
            case (avs_address)
                5'(REG_FIRST_SEL):
                    if (code_legal(wr_code))
                        first_terminal_select_reg <= wr_code;   // R2
                    else
                        reject_reg <= 1'b1;
                5'(REG_SECOND_SEL):
                    if (code_legal(wr_code) && !refuse_second)
                        second_terminal_select_reg <= wr_code;  // R3
                    else
                        reject_reg <= 1'b1;
                5'(REG_RELAY_SEL):
                    if (code_legal(wr_code) && !refuse_relay)
                        relay_terminal_select_reg <= wr_code;   // R4
                    else
                        reject_reg <= 1'b1;
                5'(REG_REMOTE):
                    remote_output_bit_reg <= avs_writedata[0];  // R12
                default:
                    if (avs_address == REG_STATUS_ADDR)
                        reject_reg <= 1'b0;   // writing status clears reject
            endcase
        end
    end

    // terminal outputs registered from selection and flag
    assign term_next = {route(relay_terminal_select_reg, fn_vec),
                        route(second_terminal_select_reg, fn_vec),
                        route(first_terminal_select_reg, fn_vec)};
    always_ff @(posedge core_clk)
    begin
        if (srst)
            {relay_terminal_on, second_terminal_on, first_terminal_on} <= 3'h0;
        else
            {relay_terminal_on, second_terminal_on, first_terminal_on} <= term_next; // R23
    end

    // bus: one wait cycle, answer at the second edge
    always_ff @(posedge core_clk)
    begin
        if (srst)
            ack_reg <= 1'b0;
        else
            ack_reg <= (avs_read || avs_write) && !ack_reg;
    end
    assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;

    // read data captured during the wait cycle
    always_ff @(posedge core_clk)
    begin
        if (srst)
            avs_readdata <= 32'h0;
        else if (avs_read && !ack_reg)
        begin
            case (avs_address)
                5'(REG_FIRST_SEL):  avs_readdata <= {18'h0, first_terminal_select_reg};
                5'(REG_SECOND_SEL): avs_readdata <= {18'h0, second_terminal_select_reg};
                5'(REG_RELAY_SEL):  avs_readdata <= {18'h0, relay_terminal_select_reg};
                5'(REG_REMOTE):     avs_readdata <= {31'h0, remote_output_bit_reg};
                REG_STATUS_ADDR:    avs_readdata <= {25'h0, reject_reg, trip_flag_reg,
                                        motion_flag, drive_ready_flag, relay_terminal_on,
                                        second_terminal_on, first_terminal_on};
                default:            avs_readdata <= 32'h0;  // unmapped reads zero
            endcase
        end
    end

    // assertions
    property p_polarity;
        @(posedge core_clk) disable iff (srst)
        (first_terminal_select_reg == 14'(FN_TRIP) + SEL_NEG_BASE)
        |=> (first_terminal_on == !$past(trip_flag_reg));
    endproperty
    a_polarity: assert property (p_polarity) else $error("negative band not inverted"); // R1

    property p_second_no_none;
        @(posedge core_clk) disable iff (srst)
        second_terminal_select_reg != SEL_NONE;
    endproperty
    a_second_no_none: assert property (p_second_no_none) else $error("second got 9999"); // R3

    property p_relay_no_curavg;
        @(posedge core_clk) disable iff (srst)
        relay_terminal_select_reg != 14'(FN_CURAVG)
        && relay_terminal_select_reg != 14'(FN_CURAVG) + SEL_NEG_BASE;
    endproperty
    a_relay_no_curavg: assert property (p_relay_no_curavg) else $error("relay got 93"); // R4

    property p_trip_hold;
        @(posedge core_clk) disable iff (srst)
        trip_flag_reg && !drive_state.fault_reset |=> trip_flag_reg;
    endproperty
    a_trip_hold: assert property (p_trip_hold) else $error("trip dropped without reset"); // R14

    property p_shutoff;
        @(posedge core_clk) disable iff (srst)
        shutoff |-> !drive_ready_flag && !motion_flag;
    endproperty
    a_shutoff: assert property (p_shutoff) else $error("ready or motion during shutoff"); // R18

    property p_no_main;
        @(posedge core_clk) disable iff (srst)
        !drive_state.main_power_ok |-> !drive_ready_flag;
    endproperty
    a_no_main: assert property (p_no_main) else $error("ready without main supply"); // R20

    property p_motion_brake;
        @(posedge core_clk) disable iff (srst)
        drive_state.dc_brake |-> !motion_flag;
    endproperty
    a_motion_brake: assert property (p_motion_brake) else $error("motion while braking"); // R17

    property p_unmapped;
        @(posedge core_clk) disable iff (srst)
        (first_terminal_select_reg == SEL_NONE) |=> !first_terminal_on;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped code conducts"); // R24

    property p_follow;
        @(posedge core_clk) disable iff (srst)
        1'b1 |=> relay_terminal_on == $past(term_next[2]);
    endproperty
    a_follow: assert property (p_follow) else $error("relay not registered"); // R23

    // routed flags reach the first terminal one edge after they are seen

    property p_sleep;
        first_terminal_select_reg == 14'(FN_SLEEP)
        |=> first_terminal_on == $past(detectors.pid_sleep);
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep not routed"); // R5

    property p_safe;
        first_terminal_select_reg == 14'(FN_SAFE)
        |=> first_terminal_on == $past(drive_state.safety_stop);
    endproperty
    a_safe: assert property (p_safe) else $error("safe not routed"); // R6

    property p_healthy;
        first_terminal_select_reg == 14'(FN_SAFETY_CIRCUIT_HEALTHY)
        |=> first_terminal_on == !$past(detectors.safety_circuit_fault || detectors.cpu_fault);
    endproperty
    a_healthy: assert property (p_healthy) else $error("healthy not routed"); // R7

    property p_life;
        first_terminal_select_reg == 14'(FN_LIFE)
        |=> first_terminal_on == $past(detectors.life_alarm_flag);
    endproperty
    a_life: assert property (p_life) else $error("life not routed"); // R8

    property p_pwroff;
        first_terminal_select_reg == 14'(FN_PWROFF)
        |=> first_terminal_on == $past(detectors.power_off_fault_flag);
    endproperty
    a_pwroff: assert property (p_pwroff) else $error("pwroff not routed"); // R9

    property p_maint;
        first_terminal_select_reg == 14'(FN_MAINT)
        |=> first_terminal_on == $past(detectors.maintenance_due_flag);
    endproperty
    a_maint: assert property (p_maint) else $error("maint not routed"); // R11

    property p_remote;
        first_terminal_select_reg == 14'(FN_REMOTE)
        |=> first_terminal_on == $past(remote_output_bit_reg);
    endproperty
    a_remote: assert property (p_remote) else $error("remote not routed"); // R12

    property p_warn;
        first_terminal_select_reg == 14'(FN_WARN)
        |=> first_terminal_on == $past(detectors.warning_flag);
    endproperty
    a_warn: assert property (p_warn) else $error("warn not routed"); // R13

    // bus: a single wait cycle, selectors change only at the acking edge
    property p_one_wait;
        avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("second wait cycle");

    property p_store_at_ack;
        avs_waitrequest |=> $stable(relay_terminal_select_reg);
    endproperty
    a_store_at_ack: assert property (p_store_at_ack) else $error("early store"); // R23

    c_undefined:  cover property (first_terminal_select_reg == 14'h0096);
    c_trip_set:   cover property (@(posedge core_clk) disable iff (srst)
                                  $rose(trip_flag_reg));
    c_trip_clear: cover property (@(posedge core_clk) disable iff (srst)
                                  $fell(trip_flag_reg));
    c_reject:     cover property (@(posedge core_clk) disable iff (srst)
                                  $rose(reject_reg));
    c_remote:     cover property (@(posedge core_clk) disable iff (srst)
                                  $rose(remote_output_bit_reg));

endmodule // status_output_router

// *** testbench/terminal_load_model.sv ***
// far-side load: lamps on the two open-collector outputs and the relay coil
// assumes terminal outputs are registered on core_clk inside the router
`timescale 1ns/1ps
module terminal_load_model
(
    input  wire logic        core_clk,
    input  wire logic        srst,
    input  wire logic        first_terminal_on,
    input  wire logic        second_terminal_on,
    input  wire logic        relay_terminal_on,
    output logic [2:0]       lamp_lit,
    output logic [15:0]      relay_switch_count
);
    logic relay_last;

    // a lamp is lit exactly while its terminal conducts
    assign lamp_lit = {relay_terminal_on, second_terminal_on, first_terminal_on};

    // count contact changes; fast toggling wears the relay out
    always_ff @(posedge core_clk)
    begin
        relay_last <= relay_terminal_on;
        if (srst)
            relay_switch_count <= 16'h0000;
        else if (relay_last != relay_terminal_on)
            relay_switch_count <= relay_switch_count + 16'h0001;
    end
endmodule // terminal_load_model

// *** testbench/status_output_router_bench.sv ***
// bench for the status output router: bus tasks, flag tables, refusals
// assumes the router package and the far-side load model are compiled first
`timescale 1ns/1ps
module status_output_router_bench import status_router_pkg::*;;
    logic         core_clk = 1'b0;
    logic         srst = 1'b1;
    logic [4:0]   avs_address = 5'h00;
    logic         avs_read = 1'b0;
    logic         avs_write = 1'b0;
    logic [31:0]  avs_writedata = 32'h0;
    logic [3:0]   avs_byteenable = 4'hf;
    logic [31:0]  avs_readdata;
    logic         avs_waitrequest;
    drive_state_s drive_state = '0;
    detector_s    detectors = '0;
    logic         first_terminal_on;
    logic         second_terminal_on;
    logic         relay_terminal_on;
    logic [2:0]   lamp_lit;
    logic [31:0]  rd;
    int           miscompares = 0;
    int           total_checks = 0;
    int           code_t [6] = '{98, 95, 93, 91, 90, 70};
    int           bit_t [6] = '{0, 1, 2, 3, 4, 7};
    logic [9:0]   ds_t [8] = '{10'h282, 10'h28a, 10'h286, 10'h380,
                               10'h080, 10'h2a2, 10'h292, 10'h2c2};
    logic [2:0]   exp_t [8] = '{3'b011, 3'b001, 3'b011, 3'b000,
                                3'b000, 3'b000, 3'b000, 3'b100};

    // 50 MHz control clock
    always #10 core_clk = ~core_clk;

    status_output_router dut (.core_clk(core_clk), .srst(srst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .drive_state(drive_state), .detectors(detectors),
        .first_terminal_on(first_terminal_on), .second_terminal_on(second_terminal_on),
        .relay_terminal_on(relay_terminal_on));

    terminal_load_model load (.core_clk(core_clk), .srst(srst),
        .first_terminal_on(first_terminal_on), .second_terminal_on(second_terminal_on),
        .relay_terminal_on(relay_terminal_on), .lamp_lit(lamp_lit), .relay_switch_count());

    // single closing point of the run
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH t=%0t word got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH t=%0t terminal got %b exp %b", $time, got, exp);
        end
    endtask

    // waitrequest sampled at each rising edge; returns at the acking edge
    task automatic wait_ack();
        int n;
        n = 0;
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0)
        begin
            n++;
            if (n > 50)
            begin
                miscompares++;
                $display("MISMATCH t=%0t bus never acknowledged", $time);
                give_verdict();
            end
            @(posedge core_clk);
        end
    endtask

    task automatic bus_write(input logic [4:0] a, input logic [31:0] d);
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= 1'b1;
        wait_ack();
        avs_write <= 1'b0;
    endtask

    task automatic bus_read(input logic [4:0] a, output logic [31:0] d);
        @(posedge core_clk);
        avs_address <= a;
        avs_read <= 1'b1;
        wait_ack();
        d = avs_readdata;
        avs_read <= 1'b0;
    endtask

    task automatic check_sel(input logic [4:0] a, input logic [31:0] exp);
        bus_read(a, rd);
        cmp_word(rd, exp);
    endtask

    // outputs follow their cause one or two edges later; three edges is ample
    task automatic settle();
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
    endtask

    task automatic set_det(input logic [9:0] v);
        @(posedge core_clk);
        detectors <= detector_s'(v);
    endtask

    task automatic set_ds(input logic [9:0] v);
        @(posedge core_clk);
        drive_state <= drive_state_s'(v);
    endtask

    // main sequence
    initial
    begin
        repeat (4) @(posedge core_clk);
        srst <= 1'b0;
        drive_state <= drive_state_s'(10'h280);
        check_sel(5'h00, 32'h0);
        check_sel(5'h08, 32'h63);
        check_sel(5'h04, 32'h1);
        bus_write(5'h04, 32'h270f);
        check_sel(5'h04, 32'h1);
        bus_read(5'h10, rd);
        cmp_bit(rd[ST_REJECT], 1'b1);
        bus_write(5'h10, 32'h0);
        bus_write(5'h08, 32'h5d);
        check_sel(5'h08, 32'h63);
        bus_write(5'h08, 32'hc1);
        check_sel(5'h08, 32'h63);
        bus_write(5'h08, 32'h270f);
        check_sel(5'h08, 32'h270f);
        bus_write(5'h00, 32'h270f);
        check_sel(5'h00, 32'h270f);
        settle();
        cmp_bit(first_terminal_on, 1'b0);
        bus_write(5'h00, 32'h32);
        settle();
        cmp_bit(first_terminal_on, 1'b0);
        bus_write(5'h00, 32'h96);
        settle();
        cmp_bit(first_terminal_on, 1'b0);
        bus_read(5'h14, rd);
        cmp_word(rd, 32'h0);
        // one function on three terminals, mixed polarity
        bus_write(5'h00, 32'h60);
        bus_write(5'h04, 32'hc4);
        bus_write(5'h08, 32'h60);
        bus_write(5'h0c, 32'h1);
        settle();
        cmp_word({29'h0, lamp_lit}, 32'h5);
        bus_write(5'h0c, 32'h0);
        settle();
        cmp_word({29'h0, lamp_lit}, 32'h2);
        for (int k = 0; k < 6; k++)
        begin
            bus_write(5'h00, code_t[k]);
            bus_write(5'h04, code_t[k] + 100);
            set_det(10'h000);
            settle();
            cmp_word({30'h0, first_terminal_on, second_terminal_on}, 32'h1);
            set_det(10'h001 << bit_t[k]);
            settle();
            cmp_word({30'h0, first_terminal_on, second_terminal_on}, 32'h2);
        end
        // healthy monitor drops on either internal fault
        bus_write(5'h00, 32'h51);
        set_det(10'h000);
        settle();
        cmp_bit(first_terminal_on, 1'b1);
        set_det(10'h020);
        settle();
        cmp_bit(first_terminal_on, 1'b0);
        set_det(10'h040);
        settle();
        cmp_bit(first_terminal_on, 1'b0);
        bus_write(5'h00, 32'h50);
        set_ds(10'h290);
        settle();
        cmp_bit(first_terminal_on, 1'b1);
        // up to frequency: direct with zero ramp time, one cycle later otherwise
        bus_write(5'h04, 32'h1);
        set_det(10'h100);
        settle();
        set_det(10'h300);
        @(posedge core_clk);
        @(negedge core_clk);
        cmp_bit(second_terminal_on, 1'b1);
        set_det(10'h000);
        settle();
        set_det(10'h200);
        @(posedge core_clk);
        @(negedge core_clk);
        cmp_bit(second_terminal_on, 1'b0);
        @(posedge core_clk);
        @(negedge core_clk);
        cmp_bit(second_terminal_on, 1'b1);
        // drive state table for ready, motion and trip
        bus_write(5'h00, 32'h0);
        bus_write(5'h08, 32'h63);
        for (int k = 0; k < 8; k++)
        begin
            set_ds(ds_t[k]);
            settle();
            bus_read(5'h10, rd);
            cmp_word({29'h0, rd[5:3]}, {29'h0, exp_t[k]});
            cmp_bit(first_terminal_on, exp_t[k][1]);
            cmp_bit(relay_terminal_on, exp_t[k][2]);
        end
        set_ds(10'h282);
        bus_write(5'h00, 32'hc7);
        settle();
        cmp_word({29'h0, lamp_lit[2], 1'b0, lamp_lit[0]}, 32'h4);
        set_ds(10'h283);
        set_ds(10'h282);
        settle();
        cmp_word({29'h0, lamp_lit[2], 1'b0, lamp_lit[0]}, 32'h1);
        give_verdict();
    end
endmodule // status_output_router_bench
